// >>> shared/wake_timer_pkg.sv
// constants, field layouts and state records of the wake-up timer
// assumes a single 250 MHz clock; register offsets are byte addresses
package wake_timer_pkg;

    // register byte addresses
    localparam logic [31:0] RELOAD_ADDR = 32'hFFFF0340;
    localparam logic [31:0] CURRENT_ADDR = 32'hFFFF0344;
    localparam logic [31:0] CONTROL_ADDR = 32'hFFFF0348;
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'hFFFF034C;
    localparam logic [31:0] EVT_STATUS_ADDR = 32'hFFFF0350;
    localparam logic [31:0] EVT_ENABLE_ADDR = 32'hFFFF0354;
    localparam logic [31:0] EVT_CLEAR_ADDR = 32'hFFFF0358;

    // reset values
    localparam logic [31:0] RELOAD_RESET = 32'h00000000;
    localparam logic [31:0] CURRENT_RESET = 32'hFFFFFFFF;
    localparam logic [10:0] CONTROL_RESET = 11'h000;
    localparam logic EVT_ENABLE_RESET = 1'h1;

    // control field positions
    localparam int CTRL_WIDTH = 11;
    localparam int CLKSEL_LSB = 9;
    localparam int DIR_BIT = 8;
    localparam int ENABLE_BIT = 7;
    localparam int PERIODIC_BIT = 6;
    localparam int FORMAT_LSB = 4;
    localparam int SCALE_LSB = 0;

    // count formats
    localparam logic [1:0] FMT_BINARY = 2'h0;
    localparam logic [1:0] FMT_HMS23 = 2'h2;
    localparam logic [1:0] FMT_HMS255 = 2'h3;

    // time-of-day field limits: hours, then {minutes, seconds, hundredths}
    localparam logic [7:0] HOUR_MAX23 = 8'h17;
    localparam logic [7:0] HOUR_MAX255 = 8'hFF;
    localparam logic [23:0] LOW_FIELD_MAX = 24'h3B3B63;

    // prescaler codes and terminal counts of the source-edge divider
    localparam logic [3:0] SCALE_1 = 4'h0;
    localparam logic [3:0] SCALE_16 = 4'h4;
    localparam logic [3:0] SCALE_256 = 4'h8;
    localparam logic [3:0] SCALE_32768 = 4'hF;
    localparam logic [14:0] TERM_1 = 15'h0000;
    localparam logic [14:0] TERM_16 = 15'h000F;
    localparam logic [14:0] TERM_256 = 15'h00FF;
    localparam logic [14:0] TERM_32768 = 15'h7FFF;

    // state of the register and counter block
    typedef struct packed {
        logic [31:0] reload;
        logic [31:0] count;
        logic [10:0] control;
        logic status;
        logic evtEnable;
        logic irq;
        logic [31:0] rdData;
    } timer_state_t;

    // state of the tick generator
    typedef struct packed {
        logic [3:0] syncA;
        logic [3:0] syncB;
        logic [3:0] prev;
        logic [14:0] preCount;
        logic tick;
    } tick_state_t;

endpackage

// >>> shared/tick_if.sv
// link between the timer core and its source/prescaler tick generator
// both ends run on the same clock
`timescale 1ns/1ps
interface tick_if;
    logic [1:0] clockSourceSelect;
    logic [3:0] prescaleSelect;
    logic run;
    logic tick;

    modport gen (input clockSourceSelect, input prescaleSelect, input run, output tick);
    modport core (output clockSourceSelect, output prescaleSelect, output run, input tick);
endinterface

// >>> rtl/wake_tick_gen.sv
// source clock select and prescaler of the wake-up timer
// source pins are asynchronous levels, each well below half the system clock
`timescale 1ns/1ps
module wake_tick_gen
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // source pins: oscillator, core-divided, crystal, undivided fast clock
    input wire logic [3:0] sourcePins,
    // link to the timer core
    tick_if.gen link
);

    wake_timer_pkg::tick_state_t st_r;
    wake_timer_pkg::tick_state_t st_nxt;
    logic srcEdge;
    logic [14:0] term;

    // ****************************************************
    // next state
    // ****************************************************
    // edges are taken from the second and third stages only
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.syncA = sourcePins;
        st_nxt.syncB = st_r.syncA;
        st_nxt.prev = st_r.syncB;
        srcEdge = st_r.syncB[link.clockSourceSelect] & ~st_r.prev[link.clockSourceSelect];
        case (link.prescaleSelect)
            wake_timer_pkg::SCALE_16: term = wake_timer_pkg::TERM_16;
            wake_timer_pkg::SCALE_256: term = wake_timer_pkg::TERM_256;
            wake_timer_pkg::SCALE_32768: term = wake_timer_pkg::TERM_32768;
            default: term = wake_timer_pkg::TERM_1; // undefined codes divide by one
        endcase
        st_nxt.tick = 1'b0;
        if (!link.run)
        begin
            st_nxt.preCount = wake_timer_pkg::TERM_1; // a restart begins a full period
        end
        else if (srcEdge)
        begin
            if (st_r.preCount >= term)
            begin
                st_nxt.preCount = wake_timer_pkg::TERM_1;
                st_nxt.tick = 1'b1;
            end
            else
            begin
                st_nxt.preCount = st_r.preCount + 15'h0001;
            end
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign link.tick = st_r.tick;

endmodule

// >>> rtl/wakeup_timer_32bit.sv
// 32-bit wake-up timer with reload, direction, periodic mode and time-of-day format
// also holds a sticky event status with its own enable and clear registers
// assumes a single-cycle register port on clk and asynchronous source pins
// assumes each source pin level is held for at least three clocks
`timescale 1ns/1ps
// Behaviour
// - 32-bit counter, down by default, up with bit 8
// - bits 10:9 pick one of four sources
// - bits 3:0 prescale by 1, 16, 256, 32768
// - source edges are sampled on clk, so counting stops while clk stops
// - bits 5:4 pick binary or time-of-day format
// - reload on overflow and on reload write
// - bit 6 periodic, reset free-running
// - count only while bit 7 set
// - any write to the timer clear register drops the interrupt, unless an overflow lands in the same cycle
// - current count readable, all ones after reset
// - reload register read/write, zero after reset
// - control 16 bits, zero reset, 15:11 reserved
module wakeup_timer_32bit
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,

    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [31:0] rdData,

    // timer clock source pins
    input wire logic oscPin,
    input wire logic coreDividedPin,
    input wire logic externalCrystalInput,
    input wire logic fastClockPin,

    // interrupt
    output logic irq
);

    // ****************************************************
    // declarations
    // ****************************************************
    wake_timer_pkg::timer_state_t st_r;
    wake_timer_pkg::timer_state_t st_nxt;
    tick_if tickBus ();

    logic [1:0] clockSourceSelect;
    logic countDirection;
    logic counterEnable;
    logic periodicSelect;
    logic [1:0] countFormat;
    logic [3:0] prescaleSelect;
    logic [7:0] hourMax;
    logic [32:0] stepResult;
    logic overflow;
    logic [31:0] wrapValue;
    logic wrReload;
    logic wrControl;
    logic wrIrqClear;
    logic wrEvtEnable;
    logic wrEvtClear;
    logic evtClear;
    logic tickTaken;
    logic loadNow;
    logic evtSet;
    logic [31:0] readWord;

    // ****************************************************
    // time-of-day stepping
    // ****************************************************
    // four byte fields: hours, minutes, seconds, hundredths;
    // a carry out of the hours field is the overflow of the count
    function automatic logic [32:0] hmsStep
    (
        input logic [31:0] cur,
        input logic up,
        input logic [7:0] hMax
    );
        logic [31:0] res;
        logic carry;
        logic [7:0] field;
        logic [7:0] lim;
        logic [31:0] limits;
        limits = {hMax, wake_timer_pkg::LOW_FIELD_MAX};
        res = cur;
        carry = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            field = cur[i * 8 +: 8];
            lim = limits[i * 8 +: 8];
            if (carry)
            begin
                if (up)
                begin
                    if (field >= lim)
                    begin
                        res[i * 8 +: 8] = 8'h00;
                    end
                    else
                    begin
                        res[i * 8 +: 8] = field + 8'h01;
                        carry = 1'b0;
                    end
                end
                else
                begin
                    if (field == 8'h00)
                    begin
                        res[i * 8 +: 8] = lim;
                    end
                    else
                    begin
                        res[i * 8 +: 8] = field - 8'h01;
                        carry = 1'b0;
                    end
                end
            end
        end
        return {carry, res};
    endfunction

    // plain binary step; carry marks a pass through the terminal value
    function automatic logic [32:0] binStep
    (
        input logic [31:0] cur,
        input logic up
    );
        logic [32:0] res;
        if (up)
        begin
            res = {1'b0, cur} + 33'h000000001;
        end
        else
        begin
            res = {(cur == 32'h00000000), cur - 32'h00000001};
        end
        return res;
    endfunction

    // ****************************************************
    // control fields
    // ****************************************************
    // plain slices; reserved bits 15:11 are never stored, so they read zero
    assign clockSourceSelect = st_r.control[wake_timer_pkg::CLKSEL_LSB +: 2];
    assign countDirection = st_r.control[wake_timer_pkg::DIR_BIT];
    assign counterEnable = st_r.control[wake_timer_pkg::ENABLE_BIT];
    assign periodicSelect = st_r.control[wake_timer_pkg::PERIODIC_BIT];
    assign countFormat = st_r.control[wake_timer_pkg::FORMAT_LSB +: 2];
    assign prescaleSelect = st_r.control[wake_timer_pkg::SCALE_LSB +: 4];

    // hand the source and prescale choice to the tick generator
    assign tickBus.clockSourceSelect = clockSourceSelect;
    assign tickBus.prescaleSelect = prescaleSelect;
    assign tickBus.run = counterEnable;

    // ****************************************************
    // tick generator
    // ****************************************************
    // samples the source pins on clk, so it stops whenever clk stops
    wake_tick_gen tickGen
    (
        .clk(clk),
        .rst(rst),
        .sourcePins({fastClockPin, externalCrystalInput, coreDividedPin, oscPin}),
        .link(tickBus.gen)
    );

    // ****************************************************
    // register decode
    // ****************************************************
    assign wrReload = wrEn && (addr == wake_timer_pkg::RELOAD_ADDR);
    assign wrControl = wrEn && (addr == wake_timer_pkg::CONTROL_ADDR);
    assign wrIrqClear = wrEn && (addr == wake_timer_pkg::IRQ_CLEAR_ADDR);

    // event registers of our own, beside the timer's four
    assign wrEvtEnable = wrEn && (addr == wake_timer_pkg::EVT_ENABLE_ADDR);
    assign wrEvtClear = wrEn && (addr == wake_timer_pkg::EVT_CLEAR_ADDR);

    // event clear: any value to the timer clear register, bit 0 to the other
    assign evtClear = wrIrqClear || (wrEvtClear && wrData[0]);

    // ****************************************************
    // count qualifiers
    // ****************************************************
    // the generator already holds off while disabled; this guards a stray tick
    assign tickTaken = tickBus.tick && counterEnable;
    // a reload write always lands in the counter, even mid-period
    assign loadNow = wrReload;
    // every pass through the terminal value raises the event
    assign evtSet = overflow;

    // ****************************************************
    // counter step
    // ****************************************************
    // the reserved format code counts as binary, a safe fall-back
    always_comb
    begin
        // the 23-hour range only for its own code, 255 hours otherwise
        if (countFormat == wake_timer_pkg::FMT_HMS23)
        begin
            hourMax = wake_timer_pkg::HOUR_MAX23;
        end
        else
        begin
            hourMax = wake_timer_pkg::HOUR_MAX255;
        end
        if ((countFormat == wake_timer_pkg::FMT_HMS23) ||
            (countFormat == wake_timer_pkg::FMT_HMS255))
        begin
            stepResult = hmsStep(st_r.count, countDirection, hourMax);
        end
        else
        begin
            stepResult = binStep(st_r.count, countDirection);
        end
        overflow = tickTaken && stepResult[32];
        wrapValue = stepResult[31:0];
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        st_nxt = st_r;

        // software-written registers
        if (wrReload)
        begin
            st_nxt.reload = wrData;
        end
        if (wrControl)
        begin
            st_nxt.control = wrData[wake_timer_pkg::CTRL_WIDTH - 1:0];
        end
        if (wrEvtEnable)
        begin
            st_nxt.evtEnable = wrData[0];
        end

        // counter: a reload write wins over a tick in the same cycle
        if (loadNow)
        begin
            st_nxt.count = wrData;
        end
        else if (tickTaken)
        begin
            if (overflow && periodicSelect)
            begin
                st_nxt.count = st_r.reload;
            end
            else
            begin
                st_nxt.count = wrapValue;
            end
        end

        // sticky event: a pass in the clearing cycle is kept, so none is lost
        if (evtSet)
        begin
            st_nxt.status = 1'b1;
        end
        else if (evtClear)
        begin
            st_nxt.status = 1'b0;
        end
        st_nxt.irq = st_nxt.status && st_nxt.evtEnable;

        // read data stand in the cycle after the strobe only
        st_nxt.rdData = 32'h00000000;
        if (rdEn)
        begin
            st_nxt.rdData = readWord;
        end
    end

    // ****************************************************
    // read multiplexer
    // ****************************************************
    // the count is read live, so a read may land one tick either side of a step
    always_comb
    begin
        readWord = 32'h00000000;
        case (addr)
            wake_timer_pkg::RELOAD_ADDR:
            begin
                readWord = st_r.reload;
            end
            wake_timer_pkg::CURRENT_ADDR:
            begin
                readWord = st_r.count;
            end
            wake_timer_pkg::CONTROL_ADDR:
            begin
                readWord = {21'h000000, st_r.control};
            end
            wake_timer_pkg::EVT_STATUS_ADDR:
            begin
                readWord = {31'h00000000, st_r.status};
            end
            wake_timer_pkg::EVT_ENABLE_ADDR:
            begin
                readWord = {31'h00000000, st_r.evtEnable};
            end
            default:
            begin
                readWord = 32'h00000000; // write-only and unmapped places read zero
            end
        endcase
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r.reload <= wake_timer_pkg::RELOAD_RESET;
            st_r.count <= wake_timer_pkg::CURRENT_RESET;
            st_r.control <= wake_timer_pkg::CONTROL_RESET;
            st_r.status <= 1'b0;
            st_r.evtEnable <= wake_timer_pkg::EVT_ENABLE_RESET;
            st_r.irq <= 1'b0;
            st_r.rdData <= 32'h00000000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    // both outputs leave straight from the state register
    assign rdData = st_r.rdData;
    assign irq = st_r.irq;

endmodule

// >>> tb/wake_timer_checker.sv
// concurrent checks of the wake-up timer register port and interrupt
// sees only the timer's top-level ports; bound to it at the foot of this file
`timescale 1ns/1ps
module wake_timer_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [31:0] rdData,
    // interrupt
    input wire logic irq
);
    logic enable_r;
    logic rlWr, rlRd, curRd, ctWr, ctRd, clrWr, clrRd, evtWr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // decoded accesses
    assign rlWr = wrEn && addr == 32'hFFFF0340;
    assign rlRd = rdEn && addr == 32'hFFFF0340;
    assign curRd = rdEn && addr == 32'hFFFF0344;
    assign ctWr = wrEn && addr == 32'hFFFF0348;
    assign ctRd = rdEn && addr == 32'hFFFF0348;
    assign clrWr = wrEn && addr == 32'hFFFF034C;
    assign clrRd = rdEn && addr == 32'hFFFF034C;
    assign evtWr = wrEn && (addr == 32'hFFFF0354 || addr == 32'hFFFF0358);

    // mirror of the enable bit; while clear no overflow can race a clear write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_r <= 1'h0;
        else if (ctWr)
            enable_r <= wrData[7];
    end

    // ****************
    // register port
    // ****************
    AST_RELOAD_READBACK: assert property (
        rlWr ##1 rlRd |=> rdData == $past(wrData, 2)) else $error("reload readback wrong");
    AST_RELOAD_LOADS_COUNT: assert property (
        rlWr ##1 curRd |=> rdData == $past(wrData, 2)) else $error("reload not loaded");
    AST_CTRL_READBACK: assert property (
        ctWr ##1 ctRd |=> rdData == {21'h0, $past(wrData[10:0], 2)})
        else $error("control readback wrong");
    AST_CTRL_RESERVED: assert property (
        ctRd |=> rdData[31:11] == 21'h0) else $error("reserved control bits set");
    AST_CLEAR_WRITE_ONLY: assert property (
        clrRd |=> rdData == 32'h0) else $error("clear register readable");

    // ****************
    // interrupt
    // ****************
    AST_IRQ_CLEAR: assert property (
        clrWr && !enable_r |=> !irq) else $error("clear write left interrupt up");
    AST_IRQ_HOLD: assert property (
        irq && !clrWr && !evtWr |=> irq) else $error("interrupt dropped uncleared");
    AST_IRQ_NEEDS_ENABLE: assert property (
        !irq && !evtWr ##1 irq |-> $past(enable_r)) else $error("interrupt while disabled");

    COV_IRQ_RISE: cover property (!irq ##1 irq);
    COV_IRQ_CLEARED: cover property (irq && clrWr);
    COV_LOAD_THEN_READ: cover property (rlWr ##1 curRd);
endmodule

bind wakeup_timer_32bit wake_timer_checker i_chk (.clk(clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq));

// >>> tb/wakeup_timer_32bit_tb.sv
// self-checking bench of the wake-up timer: registers, sources, prescaler, formats
// assumes the checker file is compiled with it; pins 0..3 follow source codes 00..11
`timescale 1ns/1ps
module wakeup_timer_32bit_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wrData = 32'h0;
    logic wrEn = 1'h0;
    logic rdEn = 1'h0;
    logic [3:0] pins = 4'h0;
    logic [31:0] rdData;
    logic irq;
    logic irqSeen;
    logic [15:0] seed = 16'h4088;
    logic [31:0] got;
    logic [31:0] r;
    int badCount = 0;
    int nChecks = 0;

    always #2 clk = ~clk;

    wakeup_timer_32bit i_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .oscPin(pins[0]),
        .coreDividedPin(pins[1]), .externalCrystalInput(pins[2]), .fastClockPin(pins[3]),
        .irq(irq));

    // ****************
    // helpers
    // ****************
    // 16-bit shift register, stepped twice per 32-bit word
    function automatic logic [31:0] nxt();
        logic [31:0] v;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[31:16] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        v[15:0] = seed;
        return v;
    endfunction

    // expected binary count after n ticks from v, no pass through a terminal value
    function automatic logic [31:0] stepExpect(input logic [31:0] v, input logic up,
        input int n);
        return up ? v + 32'(n) : v - 32'(n);
    endfunction

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e)
        begin
            badCount++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    // strobes stay up until the next access lowers them, so none is set twice in a step
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wrData <= d;
        wrEn <= 1'h1;
        @(posedge clk);
    endtask

    // data stands one cycle only, so it is taken mid-cycle; irq is sampled beside it
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        addr <= a;
        wrEn <= 1'h0;
        rdEn <= 1'h1;
        @(posedge clk);
        rdEn <= 1'h0;
        @(negedge clk);
        d = rdData;
        irqSeen = irq;
        @(posedge clk);
    endtask

    // n edges on the chosen pin; the other pins toggle at random and must be ignored
    task automatic pulse(input logic [1:0] s, input int n);
        logic [31:0] v;
        wrEn <= 1'h0;
        for (int i = 0; i < n; i++)
        begin
            v = nxt();
            pins <= v[3:0] | (4'h1 << s);
            repeat (3) @(posedge clk);
            pins <= v[7:4] & ~(4'h1 << s);
            repeat (3) @(posedge clk);
        end
        pins <= 4'h0;
        repeat (8) @(posedge clk);
    endtask

    // configure, load, count, then compare count, interrupt and status, and clear
    task automatic run(input logic [31:0] ld, input logic [31:0] c, input int n,
        input logic [31:0] e, input logic ei, input logic es);
        wr(32'hFFFF0348, c);
        wr(32'hFFFF0340, ld);
        rd(32'hFFFF0344, got);
        check(got, ld);
        pulse(c[10:9], n);
        rd(32'hFFFF0344, got);
        check(got, e);
        check({31'h0, irqSeen}, {31'h0, ei});
        rd(32'hFFFF0350, got);
        check(got, {31'h0, es});
        wr(32'hFFFF0348, 32'h0);
        r = nxt();
        wr(32'hFFFF034C, r);
        rd(32'hFFFF0350, got);
        check({31'h0, irqSeen}, 32'h0);
        check(got, 32'h0);
        wr(32'hFFFF0358, 32'h1);
    endtask

    task automatic tally_and_finish;
        if (badCount == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        // reset values, write-only and unmapped places
        rd(32'hFFFF0340, got);
        check(got, 32'h0);
        rd(32'hFFFF0350, got);
        check(got, 32'h0);
        rd(32'hFFFF0354, got);
        check(got, 32'h1);
        rd(32'hFFFF0348, got);
        check(got, 32'h0);
        wr(32'hFFFF0344, 32'h5);
        rd(32'hFFFF0344, got);
        check(got, 32'hFFFFFFFF);
        rd(32'hFFFF034C, got);
        check(got, 32'h0);
        wr(32'hFFFF0360, 32'hFFFFFFFF);
        rd(32'hFFFF0360, got);
        check(got, 32'h0);
        r = nxt();
        r[7] = 1'h0;
        wr(32'hFFFF0348, r);
        rd(32'hFFFF0348, got);
        check(got, {21'h0, r[10:0]});
        r = nxt();
        wr(32'hFFFF0340, r);
        rd(32'hFFFF0340, got);
        check(got, r);
        // every source, both directions, binary, divide by one
        for (int i = 0; i < 8; i++)
        begin
            r = nxt();
            r[31:30] = 2'h1;
            run(r, {21'h0, i[1:0], i[2], 8'h80}, 3 + i,
                stepExpect(r, i[2], 3 + i), 1'h0, 1'h0);
        end
        // prescaler: one tick per N edges, none before; then none while disabled
        run(32'h100, 32'h0684, 16'h10, 32'hFF, 1'h0, 1'h0);
        run(32'h100, 32'h0684, 16'hF, 32'h100, 1'h0, 1'h0);
        run(32'h100, 32'h0388, 16'h100, 32'h101, 1'h0, 1'h0);
        run(32'h100, 32'h048F, 16'h14, 32'h100, 1'h0, 1'h0);
        run(32'h100, 32'h0000, 16'h5, 32'h100, 1'h0, 1'h0);
        // terminal passes: free-running wraps, periodic reloads
        run(32'h0, 32'h0080, 16'h1, 32'hFFFFFFFF, 1'h1, 1'h1);
        run(32'h1, 32'h00C0, 16'h2, 32'h1, 1'h1, 1'h1);
        run(32'hFFFFFFFF, 32'h0180, 16'h1, 32'h0, 1'h1, 1'h1);
        run(32'hFFFFFFFE, 32'h01C0, 16'h2, 32'hFFFFFFFE, 1'h1, 1'h1);
        // time of day from the 32 kHz source at divide-by-256; then the reserved format at divide-by-one
        run(32'h0, 32'h00A8, 16'h100, 32'h173B3B63, 1'h1, 1'h1);
        run(32'h0, 32'h00B8, 16'h100, 32'hFF3B3B63, 1'h1, 1'h1);
        run(32'h173B3B63, 32'h01A8, 16'h100, 32'h0, 1'h1, 1'h1);
        run(32'h63, 32'h01B8, 16'h100, 32'h100, 1'h0, 1'h0);
        run(32'h0, 32'h0090, 16'h1, 32'hFFFFFFFF, 1'h1, 1'h1);
        // masked event: status still set, interrupt stays low
        wr(32'hFFFF0354, 32'h0);
        run(32'h0, 32'h0080, 16'h1, 32'hFFFFFFFF, 1'h0, 1'h1);
        wr(32'hFFFF0354, 32'h1);
        tally_and_finish;
    end

    // cuts a hang short well past the expected run length
    initial
    begin
        repeat (16'hC350) @(posedge clk);
        badCount++;
        tally_and_finish;
    end
endmodule
